// File: design/shc_map.vh
// Constants, offsets and timing for the stacklight headroom controller
`ifndef SHC_MAP_VH
`define SHC_MAP_VH
// Register byte offsets on the AXI4-Lite bus
`define SHC_A_MODE   8'h00
`define SHC_A_PAT    8'h04
`define SHC_A_COLOR  8'h08
`define SHC_A_BRIGHT 8'h0C
`define SHC_A_DATA   8'h10
`define SHC_A_CTRL   8'h14
`define SHC_A_STAT   8'h18
`define SHC_A_PWM    8'h1C
`define SHC_A_LUX    8'h20
// Mode codes
`define SHC_M_DEMO   3'h0
`define SHC_M_TEMP   3'h1
`define SHC_M_HUM    3'h2
`define SHC_M_STACK  3'h3
`define SHC_M_CAL    3'h4
`define SHC_M_FULL   3'h5
// Pattern codes
`define SHC_P_ON     3'h0
`define SHC_P_OFF    3'h1
`define SHC_P_BLINK  3'h2
`define SHC_P_TEMP   3'h3
`define SHC_P_STACK  3'h4
`define SHC_P_RUN    3'h5
`define SHC_P_LEVEL  3'h6
`define SHC_P_LAST   3'h6
// Control register bits
`define SHC_C_DYN    0
`define SHC_C_HOFF   1
// Reset values
`define SHC_RST_BRIGHT 8'hFF
`define SHC_RST_COLOR  3'h7
`define SHC_RST_DATA   24'h00_0014
`define SHC_DEMO_DATA  24'h05_0514
// Brightness and current steps
`define SHC_MID_CODE  7'h40
`define SHC_MIN_CODE  7'h01
`define SHC_CAL_B0    8'h7F
`define SHC_CAL_B1    8'h9F
`define SHC_CAL_B2    8'hFF
// Residue targets in mV, tolerance in mV
`define SHC_TGT_LOW   12'h0FA
`define SHC_TGT_MID   12'h15E
`define SHC_TGT_HIGH  12'h1F4
`define SHC_TOL_MV    12'h014
// PWM start table and ceiling
`define SHC_PWM_ST0   8'h50
`define SHC_PWM_ST1   8'h3C
`define SHC_PWM_ST2   8'h14
`define SHC_PWM_MAX   8'h64
`define SHC_PWM_PER   7'h63
// Chain geometry and timing
`define SHC_NLED      5'h13
`define SHC_TOP_BIT   5'h17
`define SHC_DIV_LAST  2'h3
`define SHC_DIV_RISE  2'h2
`define SHC_CLK_NS    10
`define SHC_TICK_NS   1000000
`define SHC_DEMO_TK   16'h0BB8
`define SHC_POLL_TK   16'h0064
`define SHC_BLINK_U   4'hA
`define SHC_RESP_OK   2'h0
`define SHC_RESP_ERR  2'h2
`endif

// File: design/shc_top.v
// Stacklight headroom controller: patterns, LED chain, supply PWM calibration
// How it works
// [R1] Seven patterns: on, off, blink, gradient, stack, run, level
// [R2] Each stack segment: own colour, on/off/blink
// [R3] LEDs driven as one chained shift register
// [R4] Brightness bit 7 selects high current range
// [R5] Range bit set: 20 mA, clear: 2 mA
// [R6] Supply target derived from commanded current, via PWM
// [R7] Residue 350 mV below 10 mA, 500 above
// [R8] Low range adds 250 mV residue target
// [R9] Calibrate from table start, step PWM by error
// [R10] Store found value, three current steps
// [R11] Runtime: stored values or dynamic re-measure
// [R12] Headroom off drives supply to maximum
// [R13] Demo mode polls ambient light for brightness
// [R14] Auto brightness high range, floor 0.16 mA
// [R15] Other modes use master brightness
// [R16] Power-up calibrates three currents, then demo
// [R17] During calibration first LED white, varying brightness
// [R18] Demo loops all patterns with auto brightness
// [R19] Headroom regulated per colour channel
// [R20] Mode codes 1 temp .. 5 full power
// [R21] Full power forces every PWM to zero
// [R22] PWM kept within 0 to 100
// [R23] One PWM step per measurement
// [R24] Step done only within tolerance
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "shc_map.vh"
module shc_top #(
  parameter TICK_CYC = `SHC_TICK_NS / `SHC_CLK_NS
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write channels
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // AXI4-Lite read channels
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // Residue voltage per colour in mV
  input  wire [11:0] red_driver_voltage_point,
  input  wire [11:0] green_driver_voltage_point,
  input  wire [11:0] blue_driver_voltage_point,
  input  wire        drv_mv_valid,
  // Ambient light sensor
  input  wire [15:0] lux_val,
  input  wire        lux_valid,
  output reg         lux_poll,
  // LED driver chain
  output reg         chain_clk,
  output reg         chain_data,
  output reg         chain_latch,
  output reg         range_high,
  output reg         meas_led_lit,
  // Supply PWM and calibration marker
  output reg  [2:0]  pwm_out,
  output reg         calibration_found_marker
);

  // Software-visible registers
  reg [2:0]  mode_r;
  reg [2:0]  pat_r;
  reg [2:0]  color_r;
  reg [7:0]  bright_r;
  reg [23:0] data_r;
  reg [1:0]  ctrl_r;
  reg [15:0] lux_r;
  // Bus holding registers
  reg        aw_hold_r;
  reg        w_hold_r;
  reg [7:0]  aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;
  // Sequencer state: 0 calibrating, 1 running
  localparam ST_CAL = 1'b0;
  localparam ST_RUN = 1'b1;
  reg        st_r;
  reg        prev_st_r;
  reg [1:0]  cal_step_r;
  reg [1:0]  prev_step_r;
  reg        cal_go;
  reg        cal_end;
  reg [23:0] cal_r [0:2];          // Stored PWM per step {b,g,r}
  // Timing
  reg [31:0] tick_cnt_r;
  reg        tick;
  reg [15:0] demo_cnt_r;
  reg [15:0] poll_cnt_r;
  reg [2:0]  demo_pat_r;
  reg [7:0]  auto_r;
  reg [11:0] blink_cnt_r;
  reg        blink_on_r;
  reg [11:0] run_cnt_r;
  reg [4:0]  run_pos_r;
  // Chain shifter
  reg        busy_r;
  reg [4:0]  sh_led_r;
  reg [4:0]  sh_bit_r;
  reg [1:0]  div_r;
  reg        lit_pend_r;
  reg [6:0]  pwm_cnt_r;

  // Data word merged under its three low byte strobes; byte 3 does not exist
  wire [23:0] data_mrg = {w_strb_r[2] ? w_data_r[23:16] : data_r[23:16],
                          w_strb_r[1] ? w_data_r[15:8] : data_r[15:8],
                          w_strb_r[0] ? w_data_r[7:0] : data_r[7:0]};

  // Effective display settings per mode
  reg [2:0]  eff_pat;
  reg [23:0] eff_dat;
  reg [2:0]  eff_col;
  reg [7:0]  act_bright;
  reg [1:0]  cur_step;
  reg [11:0] tgt_mv;
  reg [7:0]  start_pwm;
  always @* begin
    eff_pat = pat_r;
    eff_dat = data_r;
    eff_col = color_r;
    act_bright = bright_r;                                   // [R15]
    if (st_r == ST_CAL) begin
      // First LED white, brightness walks through the steps
      case (cal_step_r)                                      // [R17]
        2'h0:    act_bright = `SHC_CAL_B0;
        2'h1:    act_bright = `SHC_CAL_B1;
        default: act_bright = `SHC_CAL_B2;
      endcase
    end else if (mode_r == `SHC_M_DEMO) begin
      eff_pat = demo_pat_r;                                  // [R18]
      eff_dat = `SHC_DEMO_DATA;
      eff_col = `SHC_RST_COLOR;
      act_bright = auto_r;                                   // [R13]
    end else if (mode_r == `SHC_M_TEMP) begin
      eff_pat = `SHC_P_TEMP;                                 // [R20]
    end else if (mode_r == `SHC_M_HUM) begin
      eff_pat = `SHC_P_LEVEL;
    end
    // Current step: low range, high below 10 mA, high above
    if (!act_bright[7])                                      // [R4]
      cur_step = 2'h0;
    else if (act_bright[6:0] < `SHC_MID_CODE)
      cur_step = 2'h1;
    else
      cur_step = 2'h2;
    // Residue target and table start from commanded current
    case (cur_step)                                          // [R6]
      2'h0: begin
        tgt_mv = `SHC_TGT_LOW;                               // [R8]
        start_pwm = `SHC_PWM_ST0;
      end
      2'h1: begin
        tgt_mv = `SHC_TGT_MID;                               // [R7]
        start_pwm = `SHC_PWM_ST1;
      end
      default: begin
        tgt_mv = `SHC_TGT_HIGH;                              // [R7]
        start_pwm = `SHC_PWM_ST2;
      end
    endcase
  end

  // Headroom overrides and load of a fresh PWM set
  wire force0 = (st_r == ST_RUN) &&
                ((mode_r == `SHC_M_FULL) || ctrl_r[`SHC_C_HOFF]); // [R12] [R21]
  wire load_p = (cur_step != prev_step_r) || (st_r != prev_st_r) || cal_go;
  wire [23:0] cal_word = cal_r[cur_step];
  wire adj_en = (st_r == ST_CAL) ||
                (ctrl_r[`SHC_C_DYN] && meas_led_lit && !force0);  // [R11]
  wire [35:0] drv_mv = {blue_driver_voltage_point,
                        green_driver_voltage_point,
                        red_driver_voltage_point};
  wire [12:0] tgt_hi = {1'b0, tgt_mv} + {1'b0, `SHC_TOL_MV};
  wire [12:0] tgt_lo = {1'b0, tgt_mv};
  wire [23:0] live_bus;
  wire [2:0]  done_bus;

  // Per colour headroom loop
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_ch
      reg  [7:0]  live_r;
      reg         done_r;
      wire [12:0] mv = {1'b0, drv_mv[ch*12 +: 12]};
      wire        hi = mv > tgt_hi;
      wire        lo = (mv + {1'b0, `SHC_TOL_MV}) < tgt_lo;
      assign live_bus[ch*8 +: 8] = live_r;
      assign done_bus[ch] = done_r;
      // Too much residue raises PWM, which lowers the supply
      always @(posedge aclk) begin
        if (!aresetn) begin
          live_r <= `SHC_PWM_ST0;
          done_r <= 1'b0;
        end else if (load_p) begin
          live_r <= (st_r == ST_CAL) ? start_pwm : cal_word[ch*8 +: 8]; // [R9]
          done_r <= 1'b0;
        end else if (adj_en && drv_mv_valid) begin          // [R19]
          if (hi && live_r < `SHC_PWM_MAX)                  // [R22]
            live_r <= live_r + 8'h01;                       // [R23]
          else if (lo && live_r != 8'h00)
            live_r <= live_r - 8'h01;                       // [R23]
          done_r <= !hi && !lo;                             // [R24]
        end
      end
      // Supply PWM, 100 slots per period
      always @(posedge aclk) begin
        if (!aresetn)
          pwm_out[ch] <= 1'b0;
        else
          pwm_out[ch] <= !force0 && ({1'b0, pwm_cnt_r} < live_r); // [R21]
      end
    end
  endgenerate

  // Calibration sequencer and step memory
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_CAL;                                        // [R16]
      prev_st_r <= ST_CAL;
      prev_step_r <= 2'h0;
      cal_step_r <= 2'h0;
      cal_end <= 1'b0;
      calibration_found_marker <= 1'b0;
      cal_r[0] <= {3{`SHC_PWM_ST0}};
      cal_r[1] <= {3{`SHC_PWM_ST1}};
      cal_r[2] <= {3{`SHC_PWM_ST2}};
    end else begin
      prev_st_r <= st_r;
      prev_step_r <= cur_step;
      cal_end <= 1'b0;
      calibration_found_marker <= 1'b0;
      if (cal_go) begin
        st_r <= ST_CAL;
        cal_step_r <= 2'h0;
      end else if (st_r == ST_CAL && (&done_bus) && !load_p) begin
        cal_r[cal_step_r] <= live_bus;                       // [R10]
        calibration_found_marker <= 1'b1;
        if (cal_step_r == 2'h2) begin
          st_r <= ST_RUN;                                    // [R16]
          cal_end <= 1'b1;
        end else begin
          cal_step_r <= cal_step_r + 2'h1;                   // [R10]
        end
      end
    end
  end

  // Tick, demo rotation, poll, blink and run timers
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_r <= 32'h0000_0000;
      tick <= 1'b0;
      demo_cnt_r <= 16'h0000;
      poll_cnt_r <= 16'h0000;
      demo_pat_r <= `SHC_P_ON;
      auto_r <= `SHC_RST_BRIGHT;
      lux_poll <= 1'b0;
      lux_r <= 16'h0000;
      blink_cnt_r <= 12'h000;
      blink_on_r <= 1'b1;
      run_cnt_r <= 12'h000;
      run_pos_r <= 5'h00;
    end else begin
      tick <= (tick_cnt_r == TICK_CYC - 1);
      tick_cnt_r <= (tick_cnt_r == TICK_CYC - 1) ? 32'h0000_0000
                                                 : tick_cnt_r + 32'h0000_0001;
      lux_poll <= 1'b0;
      if (lux_valid) begin
        lux_r <= lux_val;
        // High range only, never below the minimum current code
        auto_r <= {1'b1, (lux_val[15:9] < `SHC_MIN_CODE) ? `SHC_MIN_CODE
                                                          : lux_val[15:9]}; // [R14]
      end
      if (tick) begin
        if (mode_r == `SHC_M_DEMO && st_r == ST_RUN) begin
          poll_cnt_r <= poll_cnt_r + 16'h0001;
          if (poll_cnt_r == `SHC_POLL_TK) begin
            poll_cnt_r <= 16'h0000;
            lux_poll <= 1'b1;                                // [R13]
          end
          demo_cnt_r <= demo_cnt_r + 16'h0001;
          if (demo_cnt_r == `SHC_DEMO_TK) begin
            demo_cnt_r <= 16'h0000;
            demo_pat_r <= (demo_pat_r == `SHC_P_LAST) ? `SHC_P_ON
                                                      : demo_pat_r + 3'h1; // [R18]
          end
        end
        // Blink: on and off times in units of ten ticks
        blink_cnt_r <= blink_cnt_r + 12'h001;
        if (blink_cnt_r >= (blink_on_r ? eff_dat[23:16] : eff_dat[15:8]) * `SHC_BLINK_U) begin
          blink_cnt_r <= 12'h000;
          blink_on_r <= !blink_on_r;
        end
        run_cnt_r <= run_cnt_r + 12'h001;
        if (run_cnt_r >= eff_dat[7:0] * `SHC_BLINK_U) begin
          run_cnt_r <= 12'h000;
          run_pos_r <= (run_pos_r == `SHC_NLED) ? 5'h00 : run_pos_r + 5'h01;
        end
      end
    end
  end

  // Colour mask {r,g,b} of the LED being shifted
  wire [2:0] seg = sh_led_r[4:2];
  wire [3:0] seg_cfg = eff_dat[seg*4 +: 4];
  reg  [2:0] mask;
  always @* begin
    mask = 3'h0;
    if (st_r == ST_CAL) begin
      mask = (sh_led_r == 5'h00) ? 3'h7 : 3'h0;              // [R17]
    end else begin
      case (eff_pat)                                         // [R1]
        `SHC_P_ON:    mask = ({3'h0, sh_led_r} < eff_dat[7:0]) ? eff_col : 3'h0;
        `SHC_P_OFF:   mask = 3'h0;
        `SHC_P_BLINK: mask = (blink_on_r && {3'h0, sh_led_r} < eff_dat[7:0])
                             ? eff_col : 3'h0;
        `SHC_P_TEMP: begin
          // Cold blue at the bottom, green middle, red top
          if (sh_led_r >= eff_dat[4:0]) mask = 3'h0;
          else if (seg < 3'h2)          mask = 3'h1;
          else if (seg == 3'h2)         mask = 3'h2;
          else                          mask = 3'h4;
        end
        `SHC_P_STACK: mask = (seg_cfg[0] && !blink_on_r) ? 3'h0 : seg_cfg[3:1]; // [R2]
        `SHC_P_RUN:   mask = (sh_led_r == run_pos_r) ? eff_col : 3'h0;
        `SHC_P_LEVEL: mask = (sh_led_r < eff_dat[4:0]) ? eff_col : 3'h0;
        default:      mask = 3'h0;
      endcase
    end
  end

  // Bit sent: bits 23..16 red, 15..8 green, 7..0 blue
  wire [1:0] sh_ch = (sh_bit_r > 5'h0F) ? 2'h2 : (sh_bit_r > 5'h07) ? 2'h1 : 2'h0;
  wire [7:0] sh_byte = mask[sh_ch] ? {1'b0, act_bright[6:0]} : 8'h00;

  // Chain shifter, one frame per tick, last LED first
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
      sh_led_r <= `SHC_NLED;
      sh_bit_r <= `SHC_TOP_BIT;
      div_r <= 2'h0;
      chain_clk <= 1'b0;
      chain_data <= 1'b0;
      chain_latch <= 1'b0;
      lit_pend_r <= 1'b0;
      meas_led_lit <= 1'b0;
      range_high <= 1'b0;
      pwm_cnt_r <= 7'h00;
    end else begin
      chain_latch <= 1'b0;
      range_high <= act_bright[7];                           // [R4] [R5]
      pwm_cnt_r <= (pwm_cnt_r == `SHC_PWM_PER) ? 7'h00 : pwm_cnt_r + 7'h01;
      if (!busy_r) begin
        if (tick) begin
          busy_r <= 1'b1;
          sh_led_r <= `SHC_NLED;
          sh_bit_r <= `SHC_TOP_BIT;
          div_r <= 2'h0;
        end
      end else begin
        div_r <= div_r + 2'h1;
        if (div_r == 2'h0)
          chain_data <= sh_byte[sh_bit_r[2:0]];              // [R3]
        if (div_r == `SHC_DIV_RISE)
          chain_clk <= 1'b1;
        if (div_r == `SHC_DIV_LAST) begin
          chain_clk <= 1'b0;
          if (sh_led_r == 5'h00 && sh_bit_r == `SHC_TOP_BIT)
            lit_pend_r <= |mask;
          if (sh_bit_r != 5'h00) begin
            sh_bit_r <= sh_bit_r - 5'h01;
          end else if (sh_led_r != 5'h00) begin
            sh_bit_r <= `SHC_TOP_BIT;
            sh_led_r <= sh_led_r - 5'h01;
          end else begin
            busy_r <= 1'b0;
            chain_latch <= 1'b1;                             // [R3]
            meas_led_lit <= lit_pend_r;                      // [R11]
          end
        end
      end
    end
  end

  // AXI4-Lite write side: address and data taken in either order
  assign awready = !aw_hold_r && !bvalid;
  assign wready  = !w_hold_r && !bvalid;
  wire   do_wr   = aw_hold_r && w_hold_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `SHC_RESP_OK;
      mode_r <= `SHC_M_DEMO;
      pat_r <= `SHC_P_ON;
      color_r <= `SHC_RST_COLOR;
      bright_r <= `SHC_RST_BRIGHT;
      data_r <= `SHC_RST_DATA;
      ctrl_r <= 2'h1;
      cal_go <= 1'b0;
    end else begin
      cal_go <= 1'b0;
      if (cal_end)
        mode_r <= `SHC_M_DEMO;                               // [R16]
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (do_wr) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= `SHC_RESP_OK;
        if (aw_addr_r == `SHC_A_MODE) begin
          if (w_strb_r[0]) begin
            mode_r <= w_data_r[2:0];                         // [R20]
            cal_go <= (w_data_r[2:0] == `SHC_M_CAL);
          end
        end else if (aw_addr_r == `SHC_A_PAT) begin
          if (w_strb_r[0]) pat_r <= w_data_r[2:0];
        end else if (aw_addr_r == `SHC_A_COLOR) begin
          if (w_strb_r[0]) color_r <= w_data_r[2:0];
        end else if (aw_addr_r == `SHC_A_BRIGHT) begin
          if (w_strb_r[0]) bright_r <= w_data_r[7:0];
        end else if (aw_addr_r == `SHC_A_DATA) begin
          data_r <= data_mrg;
        end else if (aw_addr_r == `SHC_A_CTRL) begin
          if (w_strb_r[0]) ctrl_r <= w_data_r[1:0];          // [R12]
        end else if (aw_addr_r == `SHC_A_STAT || aw_addr_r == `SHC_A_PWM ||
                     aw_addr_r == `SHC_A_LUX) begin
          bresp <= `SHC_RESP_OK;
        end else begin
          bresp <= `SHC_RESP_ERR;
        end
      end
    end
  end

  // AXI4-Lite read side: one-cycle answer
  assign arready = !rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `SHC_RESP_OK;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= `SHC_RESP_OK;
      if (araddr == `SHC_A_MODE)        rdata <= {29'h0, mode_r};
      else if (araddr == `SHC_A_PAT)    rdata <= {29'h0, pat_r};
      else if (araddr == `SHC_A_COLOR)  rdata <= {29'h0, color_r};
      else if (araddr == `SHC_A_BRIGHT) rdata <= {24'h0, bright_r};
      else if (araddr == `SHC_A_DATA)   rdata <= {8'h00, data_r};
      else if (araddr == `SHC_A_CTRL)   rdata <= {30'h0, ctrl_r};
      else if (araddr == `SHC_A_STAT)
        rdata <= {16'h0, act_bright, 1'b0, done_bus, cur_step, st_r, meas_led_lit};
      else if (araddr == `SHC_A_PWM)
        rdata <= {8'h00, force0 ? 24'h00_0000 : live_bus};
      else if (araddr == `SHC_A_LUX)    rdata <= {16'h0, lux_r};
      else begin
        rdata <= 32'h0000_0000;
        rresp <= `SHC_RESP_ERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// File: verif/shc_top_chk.sv
// Port-level checker for the stacklight headroom controller
`timescale 1ns/1ps
module shc_top_chk (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Register bus handshakes
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire [1:0]  bresp,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire        rvalid,
  input wire        rready,
  // Chain, sensor request and marker
  input wire        chain_clk,
  input wire        chain_data,
  input wire        chain_latch,
  input wire        lux_poll,
  input wire        calibration_found_marker
);
  // One clock domain for all
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A response stands until the master takes it
  chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid)
    else $error("read response dropped");
  // Write answer comes the cycle after both halves are held
  chk_b_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  chk_r_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  chk_b_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while busy");
  // Data settled around the single high cycle of the shift clock
  chk_shift_clk: assert property (
    $rose(chain_clk) |-> $stable(chain_data) ##1 (!chain_clk && $stable(chain_data)))
    else $error("chain shift timing wrong");
  chk_latch_once: assert property (chain_latch |=> !chain_latch && !chain_clk)
    else $error("latch not a pulse");
  chk_found_pulse: assert property (calibration_found_marker |=> !calibration_found_marker)
    else $error("marker not a pulse");
  chk_poll_pulse: assert property (lux_poll |=> !lux_poll)
    else $error("poll not a pulse");
  // Main scenarios reached
  cover property (calibration_found_marker);
  cover property (chain_latch);
  cover property (lux_poll);
  cover property (bvalid && bresp == 2'h2);
endmodule
bind shc_top shc_top_chk shc_top_chk_i (.*);

// File: verif/shc_far_model.sv
// Far-side model: driver residue voltages and ambient light sensor
`timescale 1ns/1ps
module shc_far_model (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Supply PWM and sensor request
  input  wire [2:0]  pwm_out,
  input  wire        lux_poll,
  input  wire [15:0] lux_set,
  // Readings back to the controller
  output wire [11:0] red_driver_voltage_point,
  output wire [11:0] green_driver_voltage_point,
  output wire [11:0] blue_driver_voltage_point,
  output reg         drv_mv_valid,
  output reg  [15:0] lux_val,
  output reg         lux_valid
);
  reg [6:0]  ph_r;        // Slot in the 100-cycle window
  reg [6:0]  hi_r [0:2];  // High slots seen per colour
  reg [11:0] mv_r [0:2];  // Last residue per colour
  integer    i;
  // Residue falls 8 mV per PWM slot, so each colour settles on its own
  always @(posedge aclk) begin
    if (!aresetn) begin
      ph_r <= 7'h00;
      drv_mv_valid <= 1'b0;
      lux_valid <= 1'b0;
      lux_val <= 16'h0000;
      for (i = 0; i < 3; i = i + 1) begin
        hi_r[i] <= 7'h00;
        mv_r[i] <= 12'h000;
      end
    end else begin
      ph_r <= (ph_r == 7'h63) ? 7'h00 : ph_r + 7'h01;
      drv_mv_valid <= (ph_r == 7'h63);
      for (i = 0; i < 3; i = i + 1) begin
        hi_r[i] <= (ph_r == 7'h63) ? 7'h00 : hi_r[i] + {6'h00, pwm_out[i]};
        if (ph_r == 7'h63) begin
          mv_r[i] <= 12'h384 - {2'b00, hi_r[i] + {6'h00, pwm_out[i]}, 3'b000};
        end
      end
      // Sensor answers next cycle; between answers the bus churns
      lux_valid <= lux_poll;
      lux_val <= lux_poll ? lux_set : ~lux_val;
    end
  end
  // Readings are only valid with the strobe; otherwise they show the inverted value
  assign red_driver_voltage_point   = drv_mv_valid ? mv_r[0] : ~mv_r[0];
  assign green_driver_voltage_point = drv_mv_valid ? mv_r[1] : ~mv_r[1];
  assign blue_driver_voltage_point  = drv_mv_valid ? mv_r[2] : ~mv_r[2];
endmodule

// File: verif/shc_top_test.sv
// Register-level testbench for the stacklight headroom controller
`timescale 1ns/1ps
`include "shc_map.vh"
module shc_top_test;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, drv_mv_valid, lux_valid, lux_poll;
  logic        chain_clk, chain_data, chain_latch, range_high, meas_led_lit;
  logic        calibration_found_marker;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, last;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [11:0] red_driver_voltage_point, green_driver_voltage_point;
  logic [11:0] blue_driver_voltage_point;
  logic [15:0] lux_val, lux_set;
  logic [2:0]  pwm_out;
  int          mismatches, samples_checked, marks, i, k;
  // Reset table: address, field mask, value
  logic [7:0]  t_a [0:5] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [31:0] t_m [0:5] = '{32'h7, 32'h7, 32'hFF, 32'hFF_FFFF, 32'h3, 32'h2};
  logic [31:0] t_e [0:5] = '{32'h0, 32'h7, 32'hFF, 32'h14, 32'h1, 32'h0};
  // Ambient readings and expected brightness
  logic [15:0] l_v [0:2] = '{16'h0000, 16'h1200, 16'hFE00};
  logic [7:0]  l_e [0:2] = '{8'h81, 8'h89, 8'hFF};
  shc_top #(.TICK_CYC(20)) shc_top_i (.*);
  shc_far_model shc_far_model_i (.*);
  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Count stored calibration steps
  always @(posedge aclk) if (calibration_found_marker === 1'b1) marks <= marks + 1;
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write: aw and w offered together
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    bit pa, pw;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; pa = 1; pw = 1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awready) begin awvalid <= 1'b0; pa = 0; end
      if (pw && wready) begin wvalid <= 1'b0; pw = 0; end
    end
    while (!bvalid) @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    cmp({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask
  // Read and compare
  task rc(input [7:0] a, input [31:0] m, input [31:0] e, input [1:0] er);
    araddr <= a; arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b1;
    @(posedge aclk);
    last = rdata;
    cmp(rdata & m, e);
    cmp({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask
  task results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (95000) @(posedge aclk);
    mismatches++;
    results;
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
    {awaddr, araddr, wdata, lux_set} = '0;
    wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 6; i++) rc(t_a[i], t_m[i], t_e[i], `SHC_RESP_OK);
    i = 0;
    while (marks < 3 && i < 60000) begin @(posedge aclk); i++; end
    repeat (4) @(posedge aclk);
    cmp(marks, 3);
    rc(`SHC_A_STAT, 32'h2, 32'h2, `SHC_RESP_OK);
    rc(`SHC_A_MODE, 32'h7, 32'h0, `SHC_RESP_OK);
    rc(`SHC_A_PWM, 32'h0, 32'h0, `SHC_RESP_OK);
    for (i = 0; i < 3; i++) cmp({31'h0, last[8*i+:8] <= 8'h64}, 32'h1);
    // Demo brightness follows each ambient reading
    for (k = 0; k < 3; k++) begin
      lux_set <= l_v[k];
      i = 0;
      while (lux_poll !== 1'b1 && i < 4000) begin @(posedge aclk); i++; end
      repeat (4) @(posedge aclk);
      rc(`SHC_A_STAT, 32'hFF00, {16'h0, l_e[k], 8'h0}, `SHC_RESP_OK);
      rc(`SHC_A_LUX, 32'hFFFF, {16'h0, l_v[k]}, `SHC_RESP_OK);
    end
    // Outside demo: written brightness
    wr(`SHC_A_MODE, 32'h3, `SHC_RESP_OK);
    for (i = 0; i < 2; i++) begin
      wr(`SHC_A_BRIGHT, {24'h0, i[0], 7'h05}, `SHC_RESP_OK);
      rc(`SHC_A_STAT, 32'hFF00, {16'h0, i[0], 7'h05, 8'h0}, `SHC_RESP_OK);
      cmp({31'h0, range_high}, {31'h0, i[0]});
    end
    for (i = 1; i < 6; i++) if (i != 4) begin
      wr(`SHC_A_MODE, i, `SHC_RESP_OK);
      rc(`SHC_A_MODE, 32'h7, i, `SHC_RESP_OK);
    end
    // Full power: no PWM slot may go high
    k = 0;
    repeat (200) begin @(posedge aclk); if (pwm_out !== 3'b000) k++; end
    cmp(k, 0);
    rc(`SHC_A_PWM, 32'hFF_FFFF, 32'h0, `SHC_RESP_OK);
    wr(`SHC_A_MODE, 32'h3, `SHC_RESP_OK);
    wr(`SHC_A_CTRL, 32'h2, `SHC_RESP_OK);
    repeat (200) @(posedge aclk);
    rc(`SHC_A_PWM, 32'hFF_FFFF, 32'h0, `SHC_RESP_OK);
    wr(`SHC_A_MODE, 32'h4, `SHC_RESP_OK);
    rc(`SHC_A_STAT, 32'h2, 32'h0, `SHC_RESP_OK);
    wr(8'h24, 32'h1, `SHC_RESP_ERR);
    rc(8'h24, 32'hFFFF_FFFF, 32'h0, `SHC_RESP_ERR);
    results;
  end
endmodule
